// ===== core/timer_map.svh
`ifndef TIMER_MAP_SVH
`define TIMER_MAP_SVH

// ----------------------------------------
// Register address and bit positions
// ----------------------------------------
`define TIMER_CONTROL_ADDR 8'h91
`define TIMER_CONTROL_RESET 8'h00
`define BIT_HIGH_OVF 7
`define BIT_LOW_OVF 6
`define BIT_LOW_IRQ_EN 5
`define BIT_UNUSED_HI 4
`define BIT_SPLIT 3
`define BIT_RUN 2
`define BIT_UNUSED_LO 1
`define BIT_EXT_CLK 0
`define CONTROL_RW_MASK 8'hed

// ----------------------------------------
// Prescaler counts
// ----------------------------------------
`define SYS_DIV 4'hc
`define EXT_DIV 4'h8

`endif

// ===== core/timer_pkg.sv
package timer_pkg;
  typedef logic [7:0] byte_t;
  typedef logic [2:0] bit_index_t;
  typedef enum logic [1:0] {
    SRC_DIV12 = 2'b01,
    SRC_EXT8 = 2'b10
  } tick_src_t;
endpackage

// ===== core/ext_clock_prescaler.sv
`timescale 1ns/100ps
`include "timer_map.svh"

module ext_clock_prescaler (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // External clock pin
  input wire logic ext_clk_i,
  // Tick out
  output logic ext_tick_o
);
  logic sync1_reg, sync1_next;
  logic sync2_reg, sync2_next;
  logic prev_reg, prev_next;
  logic [3:0] cnt_reg, cnt_next;
  logic tick_reg, tick_next;

  // ----------------------------------------
  // Synchroniser, edge detect, divide by 8
  // ----------------------------------------
  always_comb begin
    sync1_next = ext_clk_i;
    sync2_next = sync1_reg;
    prev_next = sync2_reg;
    cnt_next = cnt_reg;
    tick_next = 1'b0;
    if (sync2_reg && !prev_reg) begin
      if (cnt_reg == `EXT_DIV - 4'h1) begin
        cnt_next = 4'h0;
        tick_next = 1'b1;
      end else begin
        cnt_next = cnt_reg + 4'h1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      prev_reg <= 1'b0;
      cnt_reg <= 4'h0;
      tick_reg <= 1'b0;
    end else begin
      sync1_reg <= sync1_next;
      sync2_reg <= sync2_next;
      prev_reg <= prev_next;
      cnt_reg <= cnt_next;
      tick_reg <= tick_next;
    end
  end

  assign ext_tick_o = tick_reg;
endmodule

// ===== core/split_autoreload_timer.sv
`timescale 1ns/100ps
`include "timer_map.svh"

// How it works
// - High overflow flag sets when upper byte wraps from 0xff and reloads from its reload byte.
// - In 16-bit mode high flag sets when whole counter wraps 0xffff to the two reload bytes.
// - With timer interrupt enabled, high flag setting raises interrupt request.
// - Flags never cleared by hardware; only software writing zero clears them.
// - Low overflow flag sets on low byte wrap, in both modes.
// - Low irq enable plus timer interrupt enable: low overflow raises interrupt.
// - Control bits 4 and 1 read zero and ignore writes.
// - Split enable zero gives one 16-bit counter; one gives two 8-bit counters.
// - Run bit starts counting; in split mode only gates high byte.
// - External select zero counts clock/12; one counts synchronised external/8.
// - In split mode external select applies to both bytes, overridable per byte.
// - Control register at address 0x91 with byte read, byte write and single-bit write.
// - Per-byte system clock select one picks undivided clock, else defers; high byte select acts in split mode only.
// - In split mode each byte reloads from its own reload byte.
module split_autoreload_timer (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // Special-function register port
  input wire logic [7:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire timer_pkg::byte_t sfr_wdata_i,
  input wire logic sfr_bit_wr_i,
  input wire timer_pkg::bit_index_t sfr_bit_sel_i,
  input wire logic sfr_bit_val_i,
  output timer_pkg::byte_t sfr_rdata_o,
  // Clock selects and reload values
  input wire logic high_byte_system_clock_select_i,
  input wire logic low_byte_system_clock_select_i,
  input wire timer_pkg::byte_t reload_high_byte_i,
  input wire timer_pkg::byte_t reload_low_byte_i,
  input wire logic ext_clk_i,
  // Interrupt enable and request
  input wire logic timer_irq_enable_i,
  output logic irq_o,
  // Count value
  output timer_pkg::byte_t count_high_byte_o,
  output timer_pkg::byte_t count_low_byte_o
);
  import timer_pkg::*;

  byte_t timer_control_reg, timer_control_next;
  byte_t count_high_byte_reg, count_high_byte_next;
  byte_t count_low_byte_reg, count_low_byte_next;
  logic [3:0] div_reg, div_next;
  logic div_tick_reg, div_tick_next;
  logic irq_reg, irq_next;
  logic ext_tick;
  logic src_tick;
  logic high_tick, low_tick;
  logic split_mode_enable, run_control, ext_clock_select, low_overflow_irq_enable;
  logic high_wrap, low_wrap;
  tick_src_t src;

  // ----------------------------------------
  // Per-byte tick selection
  // ----------------------------------------
  function automatic logic pick_tick(input logic system_clock_sel, input logic shared_tick);
    pick_tick = system_clock_sel ? 1'b1 : shared_tick;
  endfunction

  ext_clock_prescaler u_ext (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .ext_clk_i(ext_clk_i),
    .ext_tick_o(ext_tick)
  );

  assign split_mode_enable = timer_control_reg[`BIT_SPLIT];
  assign run_control = timer_control_reg[`BIT_RUN];
  assign ext_clock_select = timer_control_reg[`BIT_EXT_CLK];
  assign low_overflow_irq_enable = timer_control_reg[`BIT_LOW_IRQ_EN];
  assign src = ext_clock_select ? SRC_EXT8 : SRC_DIV12;

  // ----------------------------------------
  // Divide-by-12 prescaler
  // ----------------------------------------
  always_comb begin
    div_tick_next = 1'b0;
    div_next = div_reg + 4'h1;
    if (div_reg == `SYS_DIV - 4'h1) begin
      div_next = 4'h0;
      div_tick_next = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      div_reg <= 4'h0;
      div_tick_reg <= 1'b0;
    end else begin
      div_reg <= div_next;
      div_tick_reg <= div_tick_next;
    end
  end

  // ----------------------------------------
  // Counters
  // ----------------------------------------
  always_comb begin
    case (src)
      SRC_DIV12: src_tick = div_tick_reg;
      SRC_EXT8: src_tick = ext_tick;
      default: src_tick = 1'b0;
    endcase
    // Each byte takes the selected source unless its own system clock select is set; 16-bit mode uses the low tick only
    high_tick = pick_tick(high_byte_system_clock_select_i, src_tick);
    low_tick = pick_tick(low_byte_system_clock_select_i, src_tick);
    count_high_byte_next = count_high_byte_reg;
    count_low_byte_next = count_low_byte_reg;
    high_wrap = 1'b0;
    low_wrap = 1'b0;
    if (split_mode_enable) begin
      if (low_tick) begin
        if (count_low_byte_reg == 8'hff) begin
          low_wrap = 1'b1;
          count_low_byte_next = reload_low_byte_i;
        end else begin
          count_low_byte_next = count_low_byte_reg + 8'h01;
        end
      end
      if (run_control && high_tick) begin
        if (count_high_byte_reg == 8'hff) begin
          high_wrap = 1'b1;
          count_high_byte_next = reload_high_byte_i;
        end else begin
          count_high_byte_next = count_high_byte_reg + 8'h01;
        end
      end
    end else if (run_control && low_tick) begin
      if (count_low_byte_reg == 8'hff) begin
        low_wrap = 1'b1;
        if (count_high_byte_reg == 8'hff) begin
          high_wrap = 1'b1;
          count_high_byte_next = reload_high_byte_i;
          count_low_byte_next = reload_low_byte_i;
        end else begin
          count_high_byte_next = count_high_byte_reg + 8'h01;
          count_low_byte_next = 8'h00;
        end
      end else begin
        count_low_byte_next = count_low_byte_reg + 8'h01;
      end
    end
  end

  // ----------------------------------------
  // Control register
  // ----------------------------------------
  always_comb begin
    timer_control_next = timer_control_reg;
    if (sfr_addr_i == `TIMER_CONTROL_ADDR) begin
      if (sfr_wr_i) begin
        timer_control_next = sfr_wdata_i & `CONTROL_RW_MASK;
      end else if (sfr_bit_wr_i) begin
        timer_control_next[sfr_bit_sel_i] = sfr_bit_val_i;
        timer_control_next = timer_control_next & `CONTROL_RW_MASK;
      end
    end
    // Hardware set wins over software clear
    if (high_wrap) begin
      timer_control_next[`BIT_HIGH_OVF] = 1'b1;
    end
    if (low_wrap) begin
      timer_control_next[`BIT_LOW_OVF] = 1'b1;
    end
    irq_next = timer_irq_enable_i &&
               (high_wrap || (low_wrap && low_overflow_irq_enable));
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      timer_control_reg <= `TIMER_CONTROL_RESET;
      count_high_byte_reg <= 8'h00;
      count_low_byte_reg <= 8'h00;
      irq_reg <= 1'b0;
    end else begin
      timer_control_reg <= timer_control_next;
      count_high_byte_reg <= count_high_byte_next;
      count_low_byte_reg <= count_low_byte_next;
      irq_reg <= irq_next;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign sfr_rdata_o = (sfr_addr_i == `TIMER_CONTROL_ADDR) ? timer_control_reg : 8'h00;
  assign irq_o = irq_reg;
  assign count_high_byte_o = count_high_byte_reg;
  assign count_low_byte_o = count_low_byte_reg;
endmodule

// ===== verification/split_autoreload_timer_props.sv
`timescale 1ns/100ps
module split_autoreload_timer_props (
  // Watched ports
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire timer_pkg::byte_t sfr_wdata_i,
  input wire logic sfr_bit_wr_i,
  input wire timer_pkg::byte_t sfr_rdata_o,
  input wire timer_pkg::byte_t reload_low_byte_i,
  input wire timer_pkg::byte_t reload_high_byte_i,
  input wire logic timer_irq_enable_i,
  input wire logic irq_o,
  input wire timer_pkg::byte_t count_high_byte_o,
  input wire timer_pkg::byte_t count_low_byte_o
);
  import timer_pkg::*;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  logic sel;
  assign sel = sfr_addr_i == 8'h91;
  sequence s_wr; sfr_wr_i && sel ##1 sel; endsequence
  sequence s_keep; sel && sfr_rdata_o[7] && !sfr_wr_i && !sfr_bit_wr_i ##1 sel; endsequence
  sequence s_quiet; !timer_irq_enable_i ##1 !timer_irq_enable_i; endsequence
  property p_wr; s_wr |-> (sfr_rdata_o & 8'h2d) == ($past(sfr_wdata_i) & 8'h2d); endproperty
  property p_unused; sel |-> sfr_rdata_o[4] == 1'b0 && sfr_rdata_o[1] == 1'b0; endproperty
  property p_addr; !sel |-> sfr_rdata_o == 8'h00; endproperty
  property p_keep; s_keep |-> sfr_rdata_o[7]; endproperty
  property p_pulse; irq_o |=> !irq_o; endproperty
  property p_quiet; s_quiet |-> !irq_o; endproperty
  property p_lstep; $changed(count_low_byte_o) |-> count_low_byte_o ==
    $past(count_low_byte_o) + 8'h01 || count_low_byte_o == $past(reload_low_byte_i); endproperty
  property p_hstep; $changed(count_high_byte_o) |-> count_high_byte_o ==
    $past(count_high_byte_o) + 8'h01 || count_high_byte_o == $past(reload_high_byte_i); endproperty
  property p_lovf; $past(count_low_byte_o) == 8'hff && $changed(count_low_byte_o) && sel
    |-> sfr_rdata_o[6]; endproperty
  property p_hovf; $past(count_high_byte_o) == 8'hff && $changed(count_high_byte_o) && sel
    |-> sfr_rdata_o[7]; endproperty
  a_wr: assert property (p_wr) else $error("control write lost");
  a_unused: assert property (p_unused) else $error("unused bit reads one");
  a_addr: assert property (p_addr) else $error("other address answers");
  a_keep: assert property (p_keep) else $error("high flag cleared alone");
  a_pulse: assert property (p_pulse) else $error("irq longer than a cycle");
  a_quiet: assert property (p_quiet) else $error("irq while disabled");
  a_lstep: assert property (p_lstep) else $error("low count bad step");
  a_hstep: assert property (p_hstep) else $error("high count bad step");
  a_lovf: assert property (p_lovf) else $error("low wrap without flag");
  a_hovf: assert property (p_hovf) else $error("high wrap without flag");
endmodule
bind split_autoreload_timer split_autoreload_timer_props u_split_autoreload_timer_props (
  .clk_i(clk_i), .rstn_i(rstn_i), .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i),
  .sfr_wdata_i(sfr_wdata_i), .sfr_bit_wr_i(sfr_bit_wr_i), .sfr_rdata_o(sfr_rdata_o),
  .reload_low_byte_i(reload_low_byte_i), .reload_high_byte_i(reload_high_byte_i),
  .timer_irq_enable_i(timer_irq_enable_i), .irq_o(irq_o),
  .count_high_byte_o(count_high_byte_o), .count_low_byte_o(count_low_byte_o));

// ===== verification/tb.sv
`timescale 1ns/100ps
module tb;
  import timer_pkg::*;
  logic clk_i = 0, rstn_i = 0, wr = 0, bw = 0, bv = 0, hs = 0, ls = 0, xc = 0, xen = 0;
  logic ien = 0, chk = 0, sel = 0, irq, seen = 0;
  logic [7:0] a = 0;
  byte_t wd = 0, rlh = 0, rll = 0, rd, ch, cl, e, w;
  bit_index_t bs = 0;
  byte_t q[$];
  int error_cnt = 0, cmp_count = 0;
  always #20 clk_i = ~clk_i;
  always #130 if (xen) xc = ~xc;
  split_autoreload_timer u_split_autoreload_timer (.clk_i(clk_i), .rstn_i(rstn_i),
    .sfr_addr_i(a), .sfr_wr_i(wr), .sfr_wdata_i(wd), .sfr_bit_wr_i(bw), .sfr_bit_sel_i(bs),
    .sfr_bit_val_i(bv), .sfr_rdata_o(rd), .high_byte_system_clock_select_i(hs),
    .low_byte_system_clock_select_i(ls), .reload_high_byte_i(rlh), .reload_low_byte_i(rll),
    .ext_clk_i(xc), .timer_irq_enable_i(ien), .irq_o(irq), .count_high_byte_o(ch),
    .count_low_byte_o(cl));
  // ----------------------------------------
  // Checking
  // ----------------------------------------
  task stop_test;
    if (error_cnt == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task cmp(byte_t exp, byte_t got);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("FAIL %0t got %h exp %h", $time, got, exp);
    end
  endtask
  always @(negedge clk_i) if (chk) cmp(q.pop_front(), sel ? {7'h00, seen} : rd);
  task wr8(logic [7:0] ad, byte_t d);
    @(posedge clk_i); a <= ad; wr <= 1; wd <= d;
    @(posedge clk_i); wr <= 0;
  endtask
  task bit1(bit_index_t i, logic v);
    @(posedge clk_i); a <= 8'h91; bw <= 1; bs <= i; bv <= v;
    @(posedge clk_i); bw <= 0;
  endtask
  task rd8(logic [7:0] ad, logic s, byte_t x);
    @(posedge clk_i); a <= ad; sel <= s; q.push_back(x); chk <= 1;
    @(posedge clk_i); chk <= 0;
  endtask
  task irqw(byte_t x);
    repeat (2) @(negedge clk_i);
    seen = 0;
    repeat (300) @(negedge clk_i) if (irq === 1'b1) seen = 1;
    rd8(8'h91, 1, x);
  endtask
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    void'($urandom(97252));
    repeat (16) @(posedge clk_i);
    rstn_i <= 1;
    rd8(8'h91, 0, 8'h00);
    repeat (4) begin
      w = $urandom;
      wr8(8'h91, w);
      rd8(8'h91, 0, w & 8'hed);
    end
    w = $urandom;
    rd8(w == 8'h91 ? 8'h00 : w, 0, 8'h00);
    wr8(8'h91, 8'h00);
    e = 8'h00;
    for (int i = 0; i < 8; i++) begin
      bit1(i, 1);
      e[i] = 1;
      rd8(8'h91, 0, e & 8'hed);
    end
    bit1(7, 0);
    rd8(8'h91, 0, 8'h6d);
    rll <= 8'hfc; ls <= 1; rlh <= 8'hfe;
    wr8(8'h91, 8'h08);
    repeat (300) @(posedge clk_i);
    rd8(8'h91, 0, 8'h48);
    ien <= 1;
    wr8(8'h91, 8'h28);
    irqw(8'h01);
    wr8(8'h91, 8'h08);
    irqw(8'h00);
    hs <= 1;
    wr8(8'h91, 8'h0c);
    irqw(8'h01);
    rd8(8'h91, 0, 8'hcc);
    hs <= 0; rll <= 8'hfe;
    wr8(8'h91, 8'h04);
    repeat (600) @(posedge clk_i);
    rd8(8'h91, 0, 8'hc4);
    rll <= 8'hff;
    wr8(8'h91, 8'h08);
    repeat (260) @(posedge clk_i);
    wr8(8'h91, 8'h00);
    wr8(8'h91, 8'h00);
    repeat (300) @(posedge clk_i);
    rd8(8'h91, 0, 8'h00);
    @(negedge clk_i);
    cmp(8'hff, cl);
    ls <= 0; rll <= 8'hff;
    wr8(8'h91, 8'h09);
    repeat (100) @(posedge clk_i);
    rd8(8'h91, 0, 8'h09);
    xen = 1;
    repeat (200) @(posedge clk_i);
    rd8(8'h91, 0, 8'h49);
    wr8(8'h91, 8'h08);
    repeat (30) @(posedge clk_i);
    rd8(8'h91, 0, 8'h48);
    stop_test;
  end
  initial begin
    #400000;
    error_cnt++;
    stop_test;
  end
endmodule
